// ### design/hsc_defs.svh
// Register map, field positions, reset values and bus constants
`ifndef HSC_DEFS_SVH
`define HSC_DEFS_SVH

// Bus address value is arbitrary
`define HSC_DEV_ADDR 7'h40
// Revision nibble value is arbitrary
`define HSC_REV 4'ha
`define HSC_BYTE_BITS 4'h8
`define HSC_LAST_BIT 4'h7

`define HSC_REG_BASE 8'h04
`define HSC_REG_LAST 8'h10
`define HSC_REG_CNT 13

`define HSC_OFF_MASK1 8'h04
`define HSC_OFF_MASK2 8'h05
`define HSC_OFF_RSV6 8'h06
`define HSC_OFF_VOL_L 8'h07
`define HSC_OFF_VOL_R 8'h08
`define HSC_OFF_MIC 8'h09
`define HSC_OFF_RSV10 8'h0a
`define HSC_OFF_REV 8'h0b
`define HSC_OFF_RSV12 8'h0c

`define HSC_RST_ZERO 8'h00
`define HSC_RST_VOL_L 8'hc0
`define HSC_RST_VOL_R 8'h40
`define HSC_RST_MIC 8'h03
`define HSC_RST_RSV12 8'h1c

`define HSC_WM_ALL 8'hff
`define HSC_WM_NONE 8'h00
`define HSC_WM_MASK1 8'hef
`define HSC_WM_MASK2 8'hf7

`define HSC_B_TRACK 7
`define HSC_B_MUTE 6
`define HSC_F_VOL 5:0
`define HSC_B_STAB 7
`define HSC_B_NOMUTE 7
`define HSC_B_PGAIN 6
`define HSC_F_BIAS_RESISTOR_SELECT 5:3
`define HSC_B_BIAS_RESISTOR_SELECT_TOP 5
`define HSC_B_BIAS 2
`define HSC_B_M2_RSV 3

`define HSC_VOL_LOW_BAND 2'h0
`define HSC_GAIN_MIN_DB 7'h56
`define HSC_GAIN_ZERO_CODE 7'h39

`endif

// ### design/hsc_pkg.sv
// Types shared by the headset control register block
package hsc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK,
    ST_WDATA, ST_DACK, ST_RDATA, ST_RACK
  } hsc_bus_st_t;

  // Status levels, bit for bit aligned with the two mask registers
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } hsc_status_t;

  typedef struct packed {
    logic [5:0] left_gain_code;
    logic [5:0] right_gain_code;
    logic left_output_silence;
    logic right_output_silence;
    logic lineout_extended_stability;
    logic preamp_press_silence_off;
    logic preamp_mute;
    logic preamp_gain_hi;
    logic [2:0] bias_resistor_select;
    logic bias_resistor_bad;
    logic bias_voltage_hi;
  } hsc_ctrl_t;

endpackage

// ### design/hsc_gain_dec.sv
// Volume code to gain in dB for one headphone channel
`timescale 1ns/1ps
`include "hsc_defs.svh"
module hsc_gain_dec import hsc_pkg::*; (
  input wire logic clk, // System clock
  input wire logic rstn, // Sync reset, low
  input wire logic [5:0] code, // Volume code
  output logic signed [6:0] db_q // Gain in dB
);
  logic signed [6:0] db_d;

  // Whole low band collapses to the floor
  always_comb begin
    if (code[5:4] == `HSC_VOL_LOW_BAND) begin
      db_d = `HSC_GAIN_MIN_DB;
    end else begin
      db_d = {1'b0, code} - `HSC_GAIN_ZERO_CODE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      db_q <= `HSC_GAIN_MIN_DB;
    end else begin
      db_q <= db_d;
    end
  end

  a_gain_floor: assert property (@(posedge clk) disable iff (!rstn)
    code[5:4] == 2'h0 |=> db_q == -7'sd42) else $error("floor gain wrong");
  a_gain_top: assert property (@(posedge clk) disable iff (!rstn)
    code == 6'h3f |=> db_q == 7'sd6) else $error("top gain wrong");
endmodule

// ### design/hsc_irq.sv
// Interrupt request from status levels gated by mask bits
`timescale 1ns/1ps
module hsc_irq import hsc_pkg::*; (
  input wire logic clk, // System clock
  input wire logic rstn, // Sync reset, low
  input wire hsc_status_t status, // Status levels
  input wire logic [15:0] mask, // Mask 1 then mask 2
  output logic irq_n_q // Interrupt, active low
);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~|(status & mask);
    end
  end

  a_irq_low: assert property (@(posedge clk) disable iff (!rstn)
    |(status & mask) |=> !irq_n_q) else $error("irq not asserted");
  a_irq_high: assert property (@(posedge clk) disable iff (!rstn)
    !(|(status & mask)) |=> irq_n_q) else $error("spurious irq");
endmodule

// ### design/hsc_regs.sv
// Headset control registers behind a two-wire serial slave
`timescale 1ns/1ps
`include "hsc_defs.svh"
module hsc_regs import hsc_pkg::*; (
  input wire logic clk, // 200 MHz system clock
  input wire logic rstn, // Sync reset, low
  input wire logic scl_in, // Serial clock level
  input wire logic sda_in, // Serial data level
  output logic sda_out_q, // Serial data drive value
  output logic sda_oe_q, // Serial data pull-down enable
  input wire hsc_status_t status_in, // Status levels
  input wire logic button_pressed, // Button held
  output logic irq_n_q, // Interrupt, active low
  output hsc_ctrl_t ctrl_q, // Analog control settings
  output logic signed [6:0] left_gain_db_q, // Left gain dB
  output logic signed [6:0] right_gain_db_q // Right gain dB
);
  localparam int IX_M1 = `HSC_OFF_MASK1 - `HSC_REG_BASE;
  localparam int IX_M2 = `HSC_OFF_MASK2 - `HSC_REG_BASE;
  localparam int IX_VL = `HSC_OFF_VOL_L - `HSC_REG_BASE;
  localparam int IX_VR = `HSC_OFF_VOL_R - `HSC_REG_BASE;
  localparam int IX_MIC = `HSC_OFF_MIC - `HSC_REG_BASE;
  localparam int IX_R10 = `HSC_OFF_RSV10 - `HSC_REG_BASE;
  localparam int IX_REV = `HSC_OFF_REV - `HSC_REG_BASE;
  localparam int IX_R12 = `HSC_OFF_RSV12 - `HSC_REG_BASE;

  hsc_bus_st_t st_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic nack_q;
  logic wr_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] regs_q [`HSC_REG_CNT];
  logic [7:0] rd_mux;
  logic [3:0] rd_idx;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic in_byte;

  function automatic logic [7:0] rst_val(input logic [7:0] off);
    unique case (off)
      `HSC_OFF_VOL_L: rst_val = `HSC_RST_VOL_L;
      `HSC_OFF_VOL_R: rst_val = `HSC_RST_VOL_R;
      `HSC_OFF_MIC: rst_val = `HSC_RST_MIC;
      `HSC_OFF_REV: rst_val = {`HSC_REV, 4'h0};
      `HSC_OFF_RSV12: rst_val = `HSC_RST_RSV12;
      default: rst_val = `HSC_RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] wmask(input logic [7:0] off);
    unique case (off)
      `HSC_OFF_MASK1: wmask = `HSC_WM_MASK1;
      `HSC_OFF_MASK2: wmask = `HSC_WM_MASK2;
      `HSC_OFF_RSV10: wmask = `HSC_WM_NONE;
      `HSC_OFF_REV: wmask = `HSC_WM_NONE;
      default: wmask = `HSC_WM_ALL;
    endcase
  endfunction

  // Inputs are synchronous, so one stored sample suffices for edges
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
  assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;
  assign in_byte = (st_q == ST_ADDR) || (st_q == ST_PTR) || (st_q == ST_WDATA);

  // Unmapped offsets read as zero
  assign rd_idx = 4'(ptr_q - `HSC_REG_BASE);
  always_comb begin
    if (ptr_q >= `HSC_REG_BASE && ptr_q <= `HSC_REG_LAST) begin
      rd_mux = regs_q[rd_idx];
    end else begin
      rd_mux = `HSC_RST_ZERO;
    end
  end

  // Open drain: only ever pulls low, value flop stays at zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wr_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (bus_start) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (bus_stop) begin
        st_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
        if (in_byte) begin
          sh_q <= {sh_q[6:0], sda_in};
          cnt_q <= cnt_q + 4'h1;
        end
        if (st_q == ST_RACK) begin
          nack_q <= sda_in;
        end
      end else if (scl_fall) begin
        unique case (st_q)
          ST_IDLE: begin
          end
          ST_ADDR: begin
            if (cnt_q == `HSC_BYTE_BITS) begin
              if (sh_q[7:1] == `HSC_DEV_ADDR) begin
                st_q <= ST_AACK;
                sda_oe_q <= 1'b1;
                rw_q <= sh_q[0];
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              st_q <= ST_RDATA;
              sda_oe_q <= ~rd_mux[7];
              tx_q <= {rd_mux[6:0], 1'b0};
            end else begin
              st_q <= ST_PTR;
              sda_oe_q <= 1'b0;
            end
          end
          ST_PTR: begin
            if (cnt_q == `HSC_BYTE_BITS) begin
              st_q <= ST_PACK;
              sda_oe_q <= 1'b1;
              ptr_q <= sh_q;
            end
          end
          ST_PACK: begin
            st_q <= ST_WDATA;
            sda_oe_q <= 1'b0;
            cnt_q <= 4'h0;
          end
          ST_WDATA: begin
            if (cnt_q == `HSC_BYTE_BITS) begin
              st_q <= ST_DACK;
              sda_oe_q <= 1'b1;
              wr_q <= 1'b1;
              wr_addr_q <= ptr_q;
              wr_data_q <= sh_q;
            end
          end
          ST_DACK: begin
            st_q <= ST_WDATA;
            sda_oe_q <= 1'b0;
            cnt_q <= 4'h0;
            ptr_q <= ptr_q + 8'h01;
          end
          ST_RDATA: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `HSC_LAST_BIT) begin
              st_q <= ST_RACK;
              sda_oe_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
            end else begin
              sda_oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            if (nack_q) begin
              st_q <= ST_IDLE;
            end else begin
              st_q <= ST_RDATA;
              cnt_q <= 4'h0;
              sda_oe_q <= ~rd_mux[7];
              tx_q <= {rd_mux[6:0], 1'b0};
            end
          end
        endcase
      end
    end
  end

  // One flop byte per offset; write mask keeps read-only bits at reset
  for (genvar gi = 0; gi < `HSC_REG_CNT; gi++) begin : g_reg
    localparam logic [7:0] OFF = 8'(`HSC_REG_BASE + gi);
    localparam logic [7:0] WM = wmask(OFF);
    always_ff @(posedge clk) begin
      if (!rstn) begin
        regs_q[gi] <= rst_val(OFF);
      end else if (wr_q && wr_addr_q == OFF) begin
        regs_q[gi] <= (wr_data_q & WM) | (regs_q[gi] & ~WM);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q.left_gain_code <= regs_q[IX_VL][`HSC_F_VOL];
      // Tracking drives right from left and ignores the right field
      ctrl_q.right_gain_code <= regs_q[IX_VL][`HSC_B_TRACK] ?
        regs_q[IX_VL][`HSC_F_VOL] : regs_q[IX_VR][`HSC_F_VOL];
      ctrl_q.left_output_silence <= regs_q[IX_VL][`HSC_B_MUTE];
      ctrl_q.right_output_silence <= regs_q[IX_VR][`HSC_B_MUTE];
      ctrl_q.lineout_extended_stability <= regs_q[IX_VR][`HSC_B_STAB];
      ctrl_q.preamp_press_silence_off <= regs_q[IX_MIC][`HSC_B_NOMUTE];
      ctrl_q.preamp_mute <= button_pressed & ~regs_q[IX_MIC][`HSC_B_NOMUTE];
      ctrl_q.preamp_gain_hi <= regs_q[IX_MIC][`HSC_B_PGAIN];
      ctrl_q.bias_resistor_select <= regs_q[IX_MIC][`HSC_F_BIAS_RESISTOR_SELECT];
      ctrl_q.bias_resistor_bad <= regs_q[IX_MIC][`HSC_B_BIAS_RESISTOR_SELECT_TOP];
      ctrl_q.bias_voltage_hi <= regs_q[IX_MIC][`HSC_B_BIAS];
    end
  end

  hsc_gain_dec u_gain_left (
    .clk(clk),
    .rstn(rstn),
    .code(ctrl_q.left_gain_code),
    .db_q(left_gain_db_q)
  );

  hsc_gain_dec u_gain_right (
    .clk(clk),
    .rstn(rstn),
    .code(ctrl_q.right_gain_code),
    .db_q(right_gain_db_q)
  );

  hsc_irq u_irq (
    .clk(clk),
    .rstn(rstn),
    .status(status_in),
    .mask({regs_q[IX_M1], regs_q[IX_M2]}),
    .irq_n_q(irq_n_q)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_track_copy: assert property (regs_q[IX_VL][7]
    |=> ctrl_q.right_gain_code == $past(regs_q[IX_VL][5:0]))
    else $error("tracking not applied");
  a_right_indep: assert property (!regs_q[IX_VL][7]
    |=> ctrl_q.right_gain_code == $past(regs_q[IX_VR][5:0]))
    else $error("right code not independent");
  // First edge out of reset still loads zeros, so start one edge later
  a_mute_out: assert property (rstn |=> ctrl_q.left_output_silence == $past(regs_q[IX_VL][6])
    && ctrl_q.right_output_silence == $past(regs_q[IX_VR][6]))
    else $error("mute mismatch");
  a_preamp_mute: assert property (button_pressed && !regs_q[IX_MIC][7]
    |=> ctrl_q.preamp_mute) else $error("preamp not muted");
  a_mic_fields: assert property (rstn |=> ctrl_q.preamp_gain_hi == $past(regs_q[IX_MIC][6])
    && ctrl_q.bias_voltage_hi == $past(regs_q[IX_MIC][2])
    && ctrl_q.bias_resistor_bad == $past(regs_q[IX_MIC][5]))
    else $error("mic field mismatch");
  a_stab_sel: assert property (rstn |=> ctrl_q.lineout_extended_stability
    == $past(regs_q[IX_VR][7])) else $error("stability mismatch");
  a_mask_write: assert property (wr_q && wr_addr_q == 8'h05
    |=> regs_q[IX_M2] == ($past(wr_data_q) & 8'hf7))
    else $error("mask 2 write wrong");
  a_mask1_write: assert property (wr_q && wr_addr_q == 8'h04
    |=> regs_q[IX_M1][2:0] == $past(wr_data_q[2:0]))
    else $error("mask 1 write wrong");
  a_ro_hold: assert property (regs_q[IX_REV] == {`HSC_REV, 4'h0}
    && regs_q[IX_R10] == 8'h00) else $error("read-only changed");
  a_reset_vals: assert property ($rose(rstn) |-> regs_q[IX_R12] == 8'h1c
    && regs_q[IX_VL] == 8'hc0 && regs_q[IX_MIC] == 8'h03)
    else $error("reset value wrong");
  a_addr_ack: assert property (scl_fall && st_q == ST_ADDR && cnt_q == 4'h8
    && sh_q[7:1] == `HSC_DEV_ADDR |=> sda_oe_q && st_q == ST_AACK)
    else $error("address not acked");

  c_write: cover property (wr_q);
  c_read_more: cover property (st_q == ST_RACK && scl_fall && !nack_q);
  c_track_off: cover property ($fell(regs_q[IX_VL][7]));
endmodule

// ### tb/hsc_host.sv
// Behavioural two-wire bus host that drives the headset register block
`timescale 1ns/1ps
`include "hsc_defs.svh"
module hsc_host (
  input wire logic clk, // Bench clock
  input wire logic sda, // Resolved data wire
  output logic scl, // Serial clock
  output logic sda_low // Host pulls data low
);
  logic ack;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves mid-low, so it is steady well before the rising clock
  task automatic bitx(input logic b, output logic r);
    scl <= 1'b0;
    w(2);
    sda_low <= ~b;
    w(2);
    scl <= 1'b1;
    w(2);
    r = sda;
    w(2);
  endtask
  // Clock falls before data moves, so no false stop is seen
  task automatic start();
    scl <= 1'b0;
    w(2);
    sda_low <= 1'b0;
    w(2);
    scl <= 1'b1;
    w(2);
    sda_low <= 1'b1;
    w(2);
  endtask
  task automatic stop();
    scl <= 1'b0;
    w(2);
    sda_low <= 1'b1;
    w(2);
    scl <= 1'b1;
    w(2);
    sda_low <= 1'b0;
    w(4);
  endtask
  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(a, ack);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
    output logic ok);
    logic [7:0] r;
    start();
    byte_x({a, 1'b0}, 1'b1, r);
    ok = ~ack;
    byte_x(p, 1'b1, r);
    ok &= ~ack;
    byte_x(d, 1'b1, r);
    ok &= ~ack;
    stop();
  endtask
  // Pointer write, repeated start, one byte read ended by a not-acknowledge
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    start();
    byte_x({`HSC_DEV_ADDR, 1'b0}, 1'b1, r);
    ok = ~ack;
    byte_x(p, 1'b1, r);
    ok &= ~ack;
    start();
    byte_x({`HSC_DEV_ADDR, 1'b1}, 1'b1, r);
    ok &= ~ack;
    byte_x(8'hff, 1'b1, d);
    stop();
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the headset control register block
`timescale 1ns/1ps
`include "hsc_defs.svh"
module tb_top import hsc_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic button_pressed = 1'b0;
  hsc_status_t status_in = '0;
  logic scl, sda_low, sda_oe_q, sda_out_q, irq_n_q, ok;
  hsc_ctrl_t ctrl_q;
  logic signed [6:0] left_gain_db_q, right_gain_db_q;
  logic [7:0] rdat;
  int m[256];
  int gc[6] = '{8'h0f, 8'h10, 8'h11, 8'h39, 8'h3f, 8'hb9};
  int n_errors = 0;
  int tests_run = 0;
  // Pull-up wire: either side may only pull it low
  wire sda = ~sda_low & (sda_oe_q ? sda_out_q : 1'b1);
  always #2.5 clk = ~clk;
  hsc_host u_hsc_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  hsc_regs u_hsc_regs (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out_q(sda_out_q),
    .sda_oe_q(sda_oe_q), .status_in(status_in), .button_pressed(button_pressed),
    .irq_n_q(irq_n_q), .ctrl_q(ctrl_q), .left_gain_db_q(left_gain_db_q),
    .right_gain_db_q(right_gain_db_q));
  function automatic int gdb(int c);
    return (c[5:4] == 0) ? -42 : c[5:0] - 57;
  endfunction
  task automatic mwr(int a, int d);
    case (a)
      4: m[a] = d & 8'hef;
      5: m[a] = d & 8'hf7;
      6, 7, 8, 9, 12, 13, 14, 15, 16: m[a] = d;
      default: ;
    endcase
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic outs();
    int rc;
    logic [22:0] ec;
    status_in <= hsc_status_t'(16'($urandom));
    button_pressed <= 1'($urandom);
    repeat (6) @(posedge clk);
    rc = m[7][7] ? m[7] : m[8];
    ec = {m[7][5:0], rc[5:0], m[7][6], m[8][6], m[8][7], m[9][7],
      button_pressed & ~m[9][7], m[9][6:3], m[9][5], m[9][2]};
    chk("ctrl", ec, ctrl_q);
    chk("sdaout", 0, sda_out_q);
    chk("ldb", {25'h0, 7'(gdb(m[7]))}, {25'h0, left_gain_db_q});
    chk("rdb", {25'h0, 7'(gdb(rc))}, {25'h0, right_gain_db_q});
    chk("irq", ~|({m[4][7:0], m[5][7:0]} & status_in), irq_n_q);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    int a, d;
    void'($urandom(32'h8165));
    m = '{default: 0};
    m[7] = 8'hc0;
    m[8] = 8'h40;
    m[9] = 8'h03;
    m[11] = {`HSC_REV, 4'h0};
    m[12] = 8'h1c;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    outs();
    // Unmapped offsets on both sides of the map read as zero
    for (a = 3; a <= 17; a++) begin
      u_hsc_host.rd(8'(a), rdat, ok);
      chk("reset", m[a], rdat);
    end
    // First pass covers every offset, read-only ones included
    for (int i = 0; i < 60; i++) begin
      a = (i < 15) ? i + 3 : 4 + $urandom % 13;
      d = $urandom % 256;
      if (a == 4) d &= 8'hee;
      if (a == 5) d &= 8'hf6;
      if (a == 9) d &= 8'hfc;
      u_hsc_host.wr(`HSC_DEV_ADDR, 8'(a), 8'(d), ok);
      mwr(a, d);
      chk("wack", 1, ok);
      u_hsc_host.rd(8'(a), rdat, ok);
      chk("rdback", m[a], rdat);
      outs();
    end
    foreach (gc[k]) begin
      u_hsc_host.wr(`HSC_DEV_ADDR, 8'h07, 8'(gc[k]), ok);
      u_hsc_host.wr(`HSC_DEV_ADDR, 8'h08, 8'(~gc[k] & 8'h3f), ok);
      mwr(7, gc[k]);
      mwr(8, ~gc[k] & 8'h3f);
      outs();
    end
    u_hsc_host.wr(7'h21, 8'h07, 8'h00, ok);
    chk("nack", 0, ok);
    u_hsc_host.rd(8'h07, rdat, ok);
    chk("keep", m[7], rdat);
    results();
  end
  initial begin
    // Full run needs about 41k cycles; this leaves ample margin
    repeat (60000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule
